// File: hw/dsp_pkg.sv
/*
 Shared constants of the dual serial register port: addresses, register
 layout, reset values and timing counts. Assumes a 10 MHz core clock.
*/
package dsp_pkg;
   // Clock and widths
   localparam int CLK_PERIOD_NS = 100;
   localparam int CHANNELS = 8;
   localparam int DATA_W = 8;
   localparam int REG_COUNT = 16;
   localparam int REG_AW = 4;
   localparam int CNT_W = 16;
   localparam int MAX_BYTES = 4;
   // Bus addresses selected by the strap
   localparam logic [6:0] I2C_ADDR_LOW = 7'h16;
   localparam logic [6:0] I2C_ADDR_HIGH = 7'h17;
   // Register map
   localparam logic [3:0] REG_DATA_BASE = 4'h0;
   localparam logic [3:0] REG_THRESHOLD = 4'h8;
   localparam logic [3:0] REG_RESULT = 4'h9;
   localparam logic [7:0] THRESHOLD_RST = 8'h80;
   localparam int SPI_READ_POS = 7;
   // Timing
   localparam int POR_TIME_NS = 1000000;
   localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MEAS_CH_TIME_NS = 2000;
   localparam int MEAS_CH_CYCLES = (MEAS_CH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MEAS_GAP_TIME_NS = 20000;
   localparam int MEAS_GAP_CYCLES = (MEAS_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LINK_HALF_NS = 1300;
   localparam int LINK_HALF_CYCLES = (LINK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: hw/dsp_link_if.sv
/*
 Pin bundle between the serial controller and the sensor port.
 Resolves the open-drain data line and the shared strap/serial-out pin.
*/
`timescale 1ns/1ps
interface dsp_link_if;
   logic scl_sck;
   logic spi_select_low;
   logic h_sda_drv;
   logic h_sda_en;
   logic d_sda_drv;
   logic d_sda_en;
   logic so_drv;
   logic so_en;
   logic addr_select_pin;
   logic sda_level;
   logic addr_select_or_serial_out;

   // Wired-AND data line with pull-up, strap seen when output idle
   assign sda_level = ~((h_sda_en & ~h_sda_drv) | (d_sda_en & ~d_sda_drv));
   assign addr_select_or_serial_out = so_en ? so_drv : addr_select_pin;

   modport dev (input scl_sck, input spi_select_low, input sda_level,
      input addr_select_or_serial_out, output d_sda_drv, output d_sda_en,
      output so_drv, output so_en);
   modport host (output scl_sck, output spi_select_low, output h_sda_drv,
      output h_sda_en, input sda_level, input addr_select_or_serial_out);
endinterface

// File: hw/dsp_port_device.sv
/*
 Sensor end: I2C and SPI register slave, power-on sequencing and the
 channel scan that fills the measurement registers.
 Assumes link pins are asynchronous to core_clk and a measured value
 per channel arrives from same-clock analog front-end logic.
*/
// Function
// - Hold power-on reset, then drop interrupt
// - Channel and result pins undefined during power-on
// - I2C write: address, register, incrementing data
// - I2C read: restart, incrementing data, final NACK
// - I2C address 0x16 or 0x17 by strap
// - SPI works in mode 0 and 3
// - SPI write stores incrementing addresses under select
// - SPI read returns incrementing addresses under select
// - Unmeasured channels driven low during measurement
// - One result output per sensor channel
// - Channel change reported as 8-bit value
// - I2C after reset; select fall enters SPI
// - External reset holds outputs high impedance, interrupt driven high
// - Interrupt goes high when measurement completes
// - Error output high on calibration or system error
`timescale 1ns/1ps
module dsp_port_device #(
   parameter int POR_CYCLES = dsp_pkg::POR_CYCLES
) (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // synchronous reset, high
   dsp_link_if.dev link, // serial pins
   input wire logic ext_reset_low, // external reset pin, low
   input wire logic [dsp_pkg::CHANNELS*dsp_pkg::DATA_W-1:0] meas_value, // per channel
   input wire logic cal_error, // calibration error event
   input wire logic sys_error, // system error event
   output logic [dsp_pkg::CHANNELS-1:0] sensor_channel_drv, // channel drive level
   output logic [dsp_pkg::CHANNELS-1:0] sensor_channel_en, // channel drive enable
   output logic [dsp_pkg::CHANNELS-1:0] channel_result_outputs, // touch judgement
   output logic result_en, // result pins enable
   output logic error_out, // error level
   output logic error_en, // error pin enable
   output logic measurement_done_irq // measurement done
);
   typedef enum logic [2:0] {
      SEQ_POR = 3'b001, SEQ_GAP = 3'b010, SEQ_MEAS = 3'b100
   } dsp_seq_t;
   typedef enum logic [6:0] {
      I_IDLE = 7'h01, I_ADDR = 7'h02, I_AACK = 7'h04, I_WR = 7'h08,
      I_WACK = 7'h10, I_RD = 7'h20, I_RACK = 7'h40
   } dsp_i2c_t;

   logic [4:0] s1_q, s2_q;
   logic [3:0] prev_q;
   logic rst_int, scl_s, sda_s, cs_s, strap_s;
   logic scl_rise, scl_fall, i2c_start, i2c_stop, cs_fall;
   logic spi_mode_q;
   dsp_seq_t seq_q;
   logic [dsp_pkg::CNT_W-1:0] cnt_q;
   logic [2:0] ch_q;
   logic irq_q, error_q, cap;
   logic [dsp_pkg::CHANNELS-1:0] result_q;
   logic [7:0] regs_q [dsp_pkg::REG_COUNT];
   logic [7:0] ch_value, i_rd, p_rd, bus_wd;
   logic [3:0] bus_wa;
   logic bus_we, wa_ok;
   dsp_i2c_t i_st_q;
   logic [7:0] i_sr_q, i_tx_q;
   logic [3:0] i_bc_q, i_ptr_q;
   logic i_first_q, i_rw_q, i_low_q, i_on, i_we, i_match;
   logic [6:0] own_addr;
   logic [7:0] p_sr_q, p_tx_q, p_byte;
   logic [2:0] p_bc_q;
   logic [3:0] p_ptr_q;
   logic p_first_q, p_rd_q, p_on, p_we;

   // Two-stage synchronisers for every pin, then a third stage for edges
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s1_q <= 5'h1F;
         s2_q <= 5'h1F;
         prev_q <= 4'hF;
      end else begin
         s1_q <= {ext_reset_low, link.scl_sck, link.sda_level, link.spi_select_low,
            link.addr_select_or_serial_out};
         s2_q <= s1_q;
         prev_q <= s2_q[3:0];
      end
   end

   // Pin decode and edge detection
   assign rst_int = sys_rst | ~s2_q[4];
   assign scl_s = s2_q[3];
   assign sda_s = s2_q[2];
   assign cs_s = s2_q[1];
   assign strap_s = s2_q[0];
   assign scl_rise = scl_s & ~prev_q[3];
   assign scl_fall = ~scl_s & prev_q[3];
   assign i2c_start = scl_s & prev_q[3] & prev_q[2] & ~sda_s;
   assign i2c_stop = scl_s & prev_q[3] & ~prev_q[2] & sda_s;
   assign cs_fall = prev_q[1] & ~cs_s;

   // Interface mode: I2C after reset, SPI after first select fall
   always_ff @(posedge core_clk) begin
      if (rst_int) spi_mode_q <= 1'b0;
      else if (cs_fall) spi_mode_q <= 1'b1;
   end

   // Power-on wait, idle gap and channel scan
   assign cap = (seq_q == SEQ_MEAS) && (cnt_q == dsp_pkg::CNT_W'(dsp_pkg::MEAS_CH_CYCLES - 1));
   always_ff @(posedge core_clk) begin
      if (rst_int) begin
         seq_q <= SEQ_POR;
         cnt_q <= '0;
         ch_q <= 3'h0;
         irq_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         case (seq_q)
            SEQ_POR: if (cnt_q == dsp_pkg::CNT_W'(POR_CYCLES - 1)) begin
               seq_q <= SEQ_GAP;
               cnt_q <= '0;
               irq_q <= 1'b0;
            end
            SEQ_GAP: if (cnt_q == dsp_pkg::CNT_W'(dsp_pkg::MEAS_GAP_CYCLES - 1)) begin
               seq_q <= SEQ_MEAS;
               cnt_q <= '0;
               ch_q <= 3'h0;
               irq_q <= 1'b0;
            end
            SEQ_MEAS: if (cap) begin
               cnt_q <= '0;
               ch_q <= ch_q + 1'b1;
               if (ch_q == 3'h7) begin
                  seq_q <= SEQ_GAP;
                  irq_q <= 1'b1;
               end
            end
            default: seq_q <= SEQ_POR;
         endcase
      end
   end

   // Judgement per channel and sticky error
   assign ch_value = meas_value[ch_q*dsp_pkg::DATA_W +: dsp_pkg::DATA_W];
   always_ff @(posedge core_clk) begin
      if (rst_int) begin
         result_q <= '0;
         error_q <= 1'b0;
      end else begin
         if (cap) result_q[ch_q] <= ch_value >= regs_q[dsp_pkg::REG_THRESHOLD];
         if (cal_error | sys_error) error_q <= 1'b1;
      end
   end

   // Pin drive: all channels high impedance in reset and power-on wait
   genvar g;
   generate
      for (g = 0; g < dsp_pkg::CHANNELS; g++) begin : g_ch
         assign sensor_channel_en[g] = (seq_q == SEQ_MEAS) && (ch_q != 3'(g));
      end
   endgenerate
   assign sensor_channel_drv = '0;
   assign result_en = seq_q != SEQ_POR;
   assign channel_result_outputs = result_q;
   assign error_en = seq_q != SEQ_POR;
   assign error_out = error_q;
   assign measurement_done_irq = irq_q;

   // Register read ports, result register shows live judgements
   assign i_rd = (i_ptr_q == dsp_pkg::REG_RESULT) ? result_q : regs_q[i_ptr_q];
   assign p_rd = (p_ptr_q == dsp_pkg::REG_RESULT) ? result_q : regs_q[p_ptr_q];

   // Bus write select; measurement and result words are read-only
   assign bus_we = spi_mode_q ? p_we : i_we;
   assign bus_wa = spi_mode_q ? p_ptr_q : i_ptr_q;
   assign bus_wd = spi_mode_q ? p_byte : i_sr_q;
   assign wa_ok = (bus_wa >= dsp_pkg::REG_THRESHOLD) && (bus_wa != dsp_pkg::REG_RESULT);
   always_ff @(posedge core_clk) begin
      if (rst_int) begin
         for (int i = 0; i < dsp_pkg::REG_COUNT; i++) regs_q[i] <= 8'h00;
         regs_q[dsp_pkg::REG_THRESHOLD] <= dsp_pkg::THRESHOLD_RST;
      end else begin
         if (cap) regs_q[dsp_pkg::REG_DATA_BASE + 4'(ch_q)] <= ch_value;
         if (bus_we && wa_ok) regs_q[bus_wa] <= bus_wd;
      end
   end

   // I2C slave byte engine
   assign i_on = ~spi_mode_q & cs_s;
   assign own_addr = strap_s ? dsp_pkg::I2C_ADDR_HIGH : dsp_pkg::I2C_ADDR_LOW;
   assign i_match = i_sr_q[7:1] == own_addr;
   assign i_we = (i_st_q == I_WR) && scl_fall && (i_bc_q == 4'h8) && ~i_first_q;
   always_ff @(posedge core_clk) begin
      if (rst_int || !i_on) begin
         i_st_q <= I_IDLE;
         i_low_q <= 1'b0;
         i_bc_q <= 4'h0;
         i_first_q <= 1'b1;
         i_rw_q <= 1'b0;
         i_ptr_q <= 4'h0;
         i_sr_q <= 8'h00;
         i_tx_q <= 8'h00;
      end else if (i2c_start) begin
         i_st_q <= I_ADDR;
         i_bc_q <= 4'h0;
         i_first_q <= 1'b1;
         i_low_q <= 1'b0;
      end else if (i2c_stop) begin
         i_st_q <= I_IDLE;
         i_low_q <= 1'b0;
      end else begin
         case (i_st_q)
            I_ADDR, I_WR: if (scl_rise) begin
               i_sr_q <= {i_sr_q[6:0], sda_s};
               i_bc_q <= i_bc_q + 1'b1;
            end else if (scl_fall && i_bc_q == 4'h8) begin
               i_bc_q <= 4'h0;
               if (i_st_q == I_WR) begin
                  i_st_q <= I_WACK;
                  i_low_q <= 1'b1;
                  i_first_q <= 1'b0;
                  i_ptr_q <= i_first_q ? i_sr_q[3:0] : i_ptr_q + 1'b1;
               end else if (i_match) begin
                  i_st_q <= I_AACK;
                  i_low_q <= 1'b1;
                  i_rw_q <= i_sr_q[0];
               end else i_st_q <= I_IDLE;
            end
            I_AACK: if (scl_fall) begin
               i_st_q <= i_rw_q ? I_RD : I_WR;
               i_tx_q <= i_rd;
               i_low_q <= i_rw_q & ~i_rd[7];
            end
            I_WACK: if (scl_fall) begin
               i_st_q <= I_WR;
               i_low_q <= 1'b0;
            end
            I_RD: if (scl_rise) i_bc_q <= i_bc_q + 1'b1;
            else if (scl_fall) begin
               if (i_bc_q == 4'h8) begin
                  i_st_q <= I_RACK;
                  i_low_q <= 1'b0;
               end else begin
                  i_tx_q <= {i_tx_q[6:0], 1'b0};
                  i_low_q <= ~i_tx_q[6];
               end
            end
            I_RACK: if (scl_rise) begin
               if (sda_s) i_st_q <= I_IDLE;
               else i_ptr_q <= i_ptr_q + 1'b1;
            end else if (scl_fall) begin
               i_st_q <= I_RD;
               i_bc_q <= 4'h0;
               i_tx_q <= i_rd;
               i_low_q <= ~i_rd[7];
            end
            default: i_st_q <= I_IDLE;
         endcase
      end
   end
   assign link.d_sda_drv = 1'b0;
   assign link.d_sda_en = i_low_q;

   // SPI slave: sample on rising, shift out on falling, so mode 0 and 3 agree
   assign p_on = spi_mode_q & ~cs_s & ~prev_q[1]; // Clock edge with select fall ignored
   assign p_byte = {p_sr_q[6:0], sda_s};
   assign p_we = p_on && scl_rise && (p_bc_q == 3'h7) && ~p_first_q && ~p_rd_q;
   always_ff @(posedge core_clk) begin
      if (rst_int || !p_on) begin
         p_bc_q <= 3'h0;
         p_first_q <= 1'b1;
         p_rd_q <= 1'b0;
         p_sr_q <= 8'h00;
         if (rst_int) p_ptr_q <= 4'h0;
         if (rst_int) p_tx_q <= 8'h00;
      end else if (scl_rise) begin
         p_sr_q <= p_byte;
         p_bc_q <= p_bc_q + 1'b1;
         if (p_bc_q == 3'h7) begin
            p_first_q <= 1'b0;
            if (p_first_q) begin
               p_rd_q <= p_byte[dsp_pkg::SPI_READ_POS];
               p_ptr_q <= p_byte[3:0];
            end else if (!p_rd_q) p_ptr_q <= p_ptr_q + 1'b1;
         end
      end else if (scl_fall && !p_first_q && p_rd_q) begin
         if (p_bc_q == 3'h0) begin
            p_tx_q <= p_rd;
            p_ptr_q <= p_ptr_q + 1'b1;
         end else p_tx_q <= {p_tx_q[6:0], 1'b0};
      end
   end
   assign link.so_drv = p_tx_q[7];
   assign link.so_en = p_on;
endmodule

// File: hw/dsp_port_host.sv
/*
 Controller end: runs one I2C or SPI burst of up to four bytes per command.
 Assumes the sensor end samples the link with its own clock; the link
 clock is made here by counting core clocks.
*/
`timescale 1ns/1ps
module dsp_port_host #(
   parameter int HALF_CYCLES = dsp_pkg::LINK_HALF_CYCLES
) (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // synchronous reset, high
   dsp_link_if.host link, // serial pins
   input wire logic cmd_valid, // command request
   output logic cmd_ready, // idle, command taken
   input wire logic cmd_spi, // 1 SPI, 0 I2C
   input wire logic cmd_mode3, // SPI mode 3 else mode 0
   input wire logic cmd_read, // read burst
   input wire logic cmd_addr_sel, // strap level of target
   input wire logic [6:0] cmd_reg, // first register
   input wire logic [2:0] cmd_len, // bytes, 1 to 4
   input wire logic [31:0] cmd_wdata, // write bytes, first low
   output logic [31:0] rd_data, // read bytes, first low
   output logic nack, // address or data refused
   output logic done // burst finished
);
   typedef enum logic [6:0] {
      H_IDLE = 7'h01, H_START = 7'h02, H_BYTE = 7'h04, H_RSTART = 7'h08,
      H_STOP = 7'h10, H_CSON = 7'h20, H_CSOFF = 7'h40
   } dsp_host_t;

   dsp_host_t st_q;
   logic [15:0] tc_q;
   logic [4:0] ss_q;
   logic [2:0] bidx_q, len_q, nb, k;
   logic [1:0] s1_q, s2_q;
   logic spi_q, m3_q, read_q, sel_q, ph2_q, scl_q, sda_q, cs_q, nack_q, done_q;
   logic [6:0] reg_q;
   logic [31:0] wd_q, rd_q;
   logic [7:0] rx_q, tx_b;
   logic [3:0] cur;
   logic step_end, rx_byte, last, bitval, in_bit;

   // Byte selection for the running burst
   assign step_end = tc_q == 16'(HALF_CYCLES - 1);
   assign cur = ss_q[4:1];
   assign nb = spi_q ? len_q + 3'h1 : (read_q ? (ph2_q ? len_q + 3'h1 : 3'h2) : len_q + 3'h2);
   assign k = bidx_q - ((spi_q | ph2_q) ? 3'h1 : 3'h2);
   assign last = bidx_q == nb - 3'h1;
   assign rx_byte = (bidx_q != 3'h0) && (spi_q ? read_q : ph2_q);
   assign tx_b = (bidx_q == 3'h0) ? (spi_q ? {read_q, reg_q} :
      {(sel_q ? dsp_pkg::I2C_ADDR_HIGH : dsp_pkg::I2C_ADDR_LOW), ph2_q}) :
      (!spi_q && bidx_q == 3'h1) ? {1'b0, reg_q} : wd_q[{k[1:0], 3'h0} +: 8];
   assign bitval = (cur == 4'h8) ? ~(rx_byte & ~last) : (rx_byte | tx_b[3'h7 - cur[2:0]]);
   assign in_bit = spi_q ? s2_q[0] : s2_q[1];

   // Two-stage synchronisers on data line and serial output
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
      end else begin
         s1_q <= {link.sda_level, link.addr_select_or_serial_out};
         s2_q <= s1_q;
      end
   end

   // Burst sequencer, one step per half link period
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_q <= H_IDLE;
         tc_q <= '0;
         ss_q <= '0;
         bidx_q <= '0;
         {spi_q, m3_q, read_q, sel_q, ph2_q, nack_q, done_q} <= '0;
         {scl_q, sda_q, cs_q} <= 3'h7;
         {len_q, reg_q, wd_q, rd_q, rx_q} <= '0;
      end else begin
         done_q <= 1'b0;
         tc_q <= step_end ? '0 : tc_q + 1'b1;
         case (st_q)
            H_IDLE: begin
               tc_q <= '0;
               ss_q <= '0;
               if (cmd_valid) begin
                  {spi_q, m3_q, read_q, sel_q} <= {cmd_spi, cmd_mode3, cmd_read, cmd_addr_sel};
                  {reg_q, len_q, wd_q} <= {cmd_reg, cmd_len, cmd_wdata};
                  {bidx_q, ph2_q, nack_q} <= '0;
                  scl_q <= cmd_spi ? cmd_mode3 : 1'b1;
                  st_q <= cmd_spi ? H_CSON : H_START;
                  if (cmd_spi) cs_q <= 1'b0;
               end
            end
            H_START: if (step_end) begin
               ss_q <= ss_q + 1'b1;
               if (ss_q == 5'h0) sda_q <= 1'b0;
               else begin
                  scl_q <= 1'b0;
                  ss_q <= '0;
                  st_q <= H_BYTE;
               end
            end
            H_CSON: if (step_end) begin
               scl_q <= 1'b0;
               st_q <= H_BYTE;
            end
            H_BYTE: begin
               if (!scl_q) sda_q <= bitval;
               if (step_end && !ss_q[0]) begin
                  scl_q <= 1'b1;
                  ss_q <= ss_q + 1'b1;
               end else if (step_end) begin
                  scl_q <= 1'b0;
                  ss_q <= ss_q + 1'b1;
                  if (cur < 4'h8) rx_q <= {rx_q[6:0], in_bit};
                  if (cur == 4'h7 && rx_byte) rd_q[{k[1:0], 3'h0} +: 8] <= {rx_q[6:0], in_bit};
                  if (cur == 4'h8 && !rx_byte && in_bit) begin
                     nack_q <= 1'b1;
                     ss_q <= '0;
                     st_q <= H_STOP;
                  end else if (ss_q == (spi_q ? 5'd15 : 5'd17)) begin
                     ss_q <= '0;
                     bidx_q <= bidx_q + 1'b1;
                     if (spi_q && last) scl_q <= m3_q; // Clock parks at idle level
                     if (last) st_q <= spi_q ? H_CSOFF : ((read_q && !ph2_q) ? H_RSTART : H_STOP);
                  end
               end
            end
            H_RSTART: if (step_end) begin
               ss_q <= ss_q + 1'b1;
               if (ss_q == 5'h0) sda_q <= 1'b1;
               else if (ss_q == 5'h1) scl_q <= 1'b1;
               else if (ss_q == 5'h2) sda_q <= 1'b0;
               else begin
                  scl_q <= 1'b0;
                  {ss_q, bidx_q} <= '0;
                  ph2_q <= 1'b1;
                  st_q <= H_BYTE;
               end
            end
            H_STOP: if (step_end) begin
               ss_q <= ss_q + 1'b1;
               if (ss_q == 5'h0) sda_q <= 1'b0;
               else if (ss_q == 5'h1) scl_q <= 1'b1;
               else if (ss_q == 5'h2) sda_q <= 1'b1;
               else begin
                  done_q <= 1'b1;
                  st_q <= H_IDLE;
               end
            end
            H_CSOFF: if (step_end) begin
               cs_q <= 1'b1;
               done_q <= 1'b1;
               st_q <= H_IDLE;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end

   // Pins: open drain for I2C, push-pull data in SPI
   assign link.scl_sck = scl_q;
   assign link.spi_select_low = cs_q;
   assign link.h_sda_drv = spi_q & sda_q;
   assign link.h_sda_en = spi_q | ~sda_q;
   assign cmd_ready = st_q == H_IDLE;
   assign rd_data = rd_q;
   assign nack = nack_q;
   assign done = done_q;
endmodule

// File: verification/dsp_link_chk.sv
/*
 Checker on the link pins between the two ends.
 Assumes one core_clk domain and a synchronous high sys_rst.
*/
`timescale 1ns/1ps
module dsp_link_chk (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // synchronous reset
   input wire logic scl_sck, // link clock
   input wire logic spi_select_low, // chip select
   input wire logic d_sda_drv, // device data value
   input wire logic d_sda_en, // device data enable
   input wire logic so_en // serial out enable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Serial output tied to the select window
   chk_so_idle_off: assert property (spi_select_low [*5] |-> !so_en)
      else $error("serial out driven while deselected");
   chk_so_on_sel: assert property ($fell(spi_select_low) |-> ##[1:5] so_en)
      else $error("serial out not driven after select");
   chk_so_off_sel: assert property ($rose(spi_select_low) |-> ##[1:5] !so_en)
      else $error("serial out not released");
   // Open-drain data line use by the device
   chk_sda_drv_low: assert property (d_sda_en |-> !d_sda_drv)
      else $error("device drives data high");
   chk_sda_spi_quiet: assert property (!spi_select_low |-> !d_sda_en)
      else $error("device pulls data in spi mode");
   chk_sda_scl_low: assert property ($changed(d_sda_en) |-> !scl_sck)
      else $error("device data changed with clock high");
   chk_ack_hold: assert property ($rose(d_sda_en) |=> d_sda_en [*8])
      else $error("device low bit too short");
   chk_sck_half: assert property ($changed(scl_sck) |=> $stable(scl_sck) [*8])
      else $error("link clock half period too short");
   // Main traffic seen
   cover property ($rose(d_sda_en));
   cover property ($fell(spi_select_low));
   cover property (so_en && scl_sck);
endmodule

// File: verification/test_dual_serial_register_port.sv
/*
 Testbench joining controller and sensor ends over the link interface.
 Assumes a 10 MHz core clock and a shortened power-on wait.
*/
`timescale 1ns/1ps
`define CHECK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_mismatch++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end
module test_dual_serial_register_port;
   logic core_clk = 1'h0;
   logic sys_rst = 1'h1;
   logic cmd_valid = 1'h0;
   logic cmd_spi = 1'h0;
   logic cmd_mode3 = 1'h0;
   logic cmd_read = 1'h0;
   logic cmd_addr_sel = 1'h0;
   logic ext_reset_low = 1'h1;
   logic cal_error = 1'h0;
   logic sys_error = 1'h0;
   logic strap = 1'h0;
   logic [6:0] cmd_reg = 7'h0;
   logic [2:0] cmd_len = 3'h1;
   logic [31:0] cmd_wdata = 32'h0;
   logic [63:0] meas_value = 64'hE0C0A08060402000;
   logic cmd_ready, nack, done, result_en, error_out, error_en, measurement_done_irq;
   logic [31:0] rd_data;
   logic [7:0] sensor_channel_drv, sensor_channel_en, channel_result_outputs;
   int n_mismatch = 0;
   int checked = 0;

   // Both ends and the pin checker
   dsp_link_if dsp_link_if_i ();
   assign dsp_link_if_i.addr_select_pin = strap;
   dsp_port_host dsp_port_host_i (.core_clk(core_clk), .sys_rst(sys_rst), .link(dsp_link_if_i),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_spi(cmd_spi), .cmd_mode3(cmd_mode3),
      .cmd_read(cmd_read), .cmd_addr_sel(cmd_addr_sel), .cmd_reg(cmd_reg), .cmd_len(cmd_len),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .nack(nack), .done(done));
   dsp_port_device #(.POR_CYCLES(50)) dsp_port_device_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .link(dsp_link_if_i), .ext_reset_low(ext_reset_low), .meas_value(meas_value),
      .cal_error(cal_error), .sys_error(sys_error), .sensor_channel_drv(sensor_channel_drv),
      .sensor_channel_en(sensor_channel_en), .channel_result_outputs(channel_result_outputs),
      .result_en(result_en), .error_out(error_out), .error_en(error_en),
      .measurement_done_irq(measurement_done_irq));
   dsp_link_chk dsp_link_chk_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .scl_sck(dsp_link_if_i.scl_sck), .spi_select_low(dsp_link_if_i.spi_select_low),
      .d_sda_drv(dsp_link_if_i.d_sda_drv), .d_sda_en(dsp_link_if_i.d_sda_en),
      .so_en(dsp_link_if_i.so_en));

   // Core clock
   initial begin
      forever #50 core_clk = ~core_clk;
   end

   // One burst: hold command until taken, then wait for done
   task automatic run(input logic spi, m3, rd, sel, input logic [6:0] rg,
         input logic [2:0] len, input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      #1;
      {cmd_spi, cmd_mode3, cmd_read, cmd_addr_sel} = {spi, m3, rd, sel};
      {cmd_reg, cmd_len, cmd_wdata} = {rg, len, wd};
      cmd_valid = 1'h1;
      // Ready looked at once settled, the next edge takes it
      while (cmd_ready !== 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      #1;
      cmd_valid = 1'h0;
      n = 0;
      while (done !== 1'b1 && n < 30000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      `CHECK("burst done", 1'b1, done)
   endtask

   // Counts and verdict
   task automatic stop_test;
      $display("Checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (90000) @(posedge core_clk);
      n_mismatch++;
      stop_test;
   end

   // Test sequence
   initial begin
      repeat (20) @(posedge core_clk);
      #1 sys_rst = 1'h0;
      repeat (10) @(posedge core_clk);
      `CHECK("irq wait", 1'b1, measurement_done_irq)
      repeat (60) @(posedge core_clk);
      `CHECK("irq release", 1'b0, measurement_done_irq)
      `CHECK("result en", 1'b1, result_en)
      `CHECK("error idle", 1'b0, error_out)
      $display("Test power-on done");
      for (int s = 0; s < 2; s++) begin
         #1 strap = s[0];
         run(1'h0, 1'h0, 1'h0, s[0], 7'h0A, 3'h4, 32'h44332211 + s);
         `CHECK("i2c ack", 1'b0, nack)
         run(1'h0, 1'h0, 1'h1, s[0], 7'h0A, 3'h4, 32'h0);
         `CHECK("i2c burst", 32'h44332211 + s, rd_data)
         run(1'h0, 1'h0, 1'h0, ~s[0], 7'h0A, 3'h1, 32'h0);
         `CHECK("i2c foreign", 1'b1, nack)
      end
      run(1'h0, 1'h0, 1'h1, 1'h1, 7'h08, 3'h1, 32'h0);
      `CHECK("threshold", 8'h80, rd_data[7:0])
      `CHECK("results", 8'hF0, channel_result_outputs)
      `CHECK("channel drive", 8'h00, sensor_channel_drv)
      $display("Test i2c done");
      for (int m = 0; m < 2; m++) begin
         run(1'h1, m[0], 1'h0, 1'h1, 7'h0C, 3'h2, 32'h00005AA5 + m);
         run(1'h1, ~m[0], 1'h1, 1'h1, 7'h0C, 3'h2, 32'h0);
         `CHECK("spi burst", 16'h5AA5 + m, rd_data[15:0])
      end
      run(1'h1, 1'h0, 1'h1, 1'h1, 7'h04, 3'h4, 32'h0);
      `CHECK("spi values", 32'hE0C0A080, rd_data)
      run(1'h0, 1'h0, 1'h1, 1'h1, 7'h08, 3'h1, 32'h0);
      `CHECK("i2c in spi", 1'b1, nack)
      $display("Test spi done");
      cal_error = 1'h1;
      @(posedge core_clk);
      #1 cal_error = 1'h0;
      repeat (4) @(posedge core_clk);
      `CHECK("error set", 1'b1, error_out)
      $display("Test error done");
      #1 ext_reset_low = 1'h0;
      repeat (6) @(posedge core_clk);
      `CHECK("ext reset", 10'h000, {result_en, error_en, sensor_channel_en})
      `CHECK("reset irq", 1'b1, measurement_done_irq)
      #1 ext_reset_low = 1'h1;
      repeat (60) @(posedge core_clk);
      `CHECK("ext release", 2'h0, {measurement_done_irq, error_out})
      repeat (440) @(posedge core_clk);
      `CHECK("scan irq", 1'b1, measurement_done_irq)
      run(1'h0, 1'h0, 1'h1, 1'h1, 7'h0C, 3'h1, 32'h0);
      `CHECK("i2c after reset", 9'h000, {nack, rd_data[7:0]})
      $display("Test reset done");
      stop_test;
   end
endmodule
